/* File: common/lmm_pkg.sv */
/*
 * Package for the linear-regulator event mask and buck load-current measurement slice:
 * register offsets, field positions, reset values and carrier structs.
 * Assumes an 8-bit register port with 8-bit addresses, decoded by the device's serial
 * host interface outside this block.
 */
package lmm_pkg;

   // ==========================================================================
   // register offsets
   localparam logic [7:0] OFS_LDO_EVENT_MASK    = 8'h23;
   localparam logic [7:0] OFS_LOAD_MEAS_SELECT  = 8'h24;
   localparam logic [7:0] OFS_LOAD_CURRENT_HIGH = 8'h25;
   localparam logic [7:0] OFS_LOAD_CURRENT_LOW  = 8'h26;

   // ==========================================================================
   // field positions in the event mask and select registers
   localparam int BIT_REG1_PG_FALL = 7;
   localparam int BIT_REG1_PG_RISE = 6;
   localparam int BIT_REG1_OC      = 4;
   localparam int BIT_REG0_PG_FALL = 3;
   localparam int BIT_REG0_PG_RISE = 2;
   localparam int BIT_REG0_OC      = 0;
   localparam logic [7:0] MASK_WRITABLE = 8'hDD;   // bits 5 and 1 read zero
   localparam int BIT_BUCK_SELECT  = 0;

   // ==========================================================================
   // reset values
   localparam logic [7:0] RST_LDO_EVENT_MASK = 8'h00;
   localparam logic       RST_BUCK_SELECT    = 1'b0;
   localparam logic [8:0] RST_LOAD_CURRENT   = 9'h000;

   // ==========================================================================
   // carrier types
   typedef struct packed {
      logic       wrEn;
      logic       rdEn;
      logic [7:0] addr;
      logic [7:0] wdata;
   } lmm_regreq_t;

   // per-regulator live conditions from the analogue side
   typedef struct packed {
      logic pgood;
      logic overcurrent;
   } lmm_regcond_t;

endpackage

/* File: hw/lmm_regs.sv */
/*
 * Register slice for linear-regulator interrupt masks and buck load-current measurement.
 * Assumes the serial host interface presents one-cycle read/write strobes on clk, that
 * regulator conditions arrive asynchronously from analogue circuits, and that the
 * measurement engine answers a start pulse with a done pulse and a 9-bit result.
 */
// What this block does
// R1: mask bit 7 blocks regulator1 power-good fall
// R2: mask bit 6 blocks regulator1 power-good rise
// R3: mask bit 4 blocks regulator1 overcurrent interrupt
// R4: mask bit 3 blocks regulator0 power-good fall
// R5: mask bit 2 blocks regulator0 power-good rise
// R6: mask bit 0 blocks regulator0 overcurrent interrupt
// R7: status keeps tracking regardless of masks
// R8: select bit 0 picks buck, resets zero
// R9: any select write starts a measurement
// R10: master selected with dualPhase reports master plus slave
// R11: slave selected reports its own current
// R12: result bit 8 in high register bit0
// R13: result low byte in low register
// R14: completion raises maskable measurement-ready interrupt
// R15: result held until next measurement completes
`timescale 1ns/10ps
module lmm_regs
(
   // clock, reset, enable
   input  wire logic                  clk,
   input  wire logic                  resetn,
   input  wire logic                  clkEn,
   // register port
   input  wire lmm_pkg::lmm_regreq_t  regReq,
   output      logic [7:0]            regRdata,
   // regulator conditions, asynchronous
   input  wire lmm_pkg::lmm_regcond_t reg0Cond,
   input  wire lmm_pkg::lmm_regcond_t reg1Cond,
   // measurement engine
   output      logic                  measStart,
   output      logic                  measBuck,
   input  wire logic                  measDone,
   input  wire logic [8:0]            phase0Current,
   input  wire logic [8:0]            phase1Current,
   input  wire logic                  dualPhase,
   input  wire logic                  meas_ready_irq_block,
   // interrupt events and live status
   output      logic                  reg0_pg_irq_flag,
   output      logic                  reg1_pg_irq_flag,
   output      logic                  reg0_overcurrent_irq_flag,
   output      logic                  reg1_overcurrent_irq_flag,
   output      logic                  meas_ready_irq_flag,
   output      logic [3:0]            linear_reg_status
);

   // ==========================================================================
   // input synchronisers
   // three stages; the first stage is seen only by the second
   logic [3:0] syncA;
   logic [3:0] syncB;
   logic [3:0] syncC;
   logic [3:0] condState;
   logic [3:0] next_condState;
   logic [3:0] rawCond;

   assign rawCond = {reg1Cond.overcurrent, reg1Cond.pgood,
                     reg0Cond.overcurrent, reg0Cond.pgood};

   // accept a change only when the two later stages agree
   always_comb
   begin
      for (int i = 0; i < 4; i++)
         next_condState[i] = (syncB[i] == syncC[i]) ? syncC[i] : condState[i];
   end

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         syncA     <= 4'h0;
         syncB     <= 4'h0;
         syncC     <= 4'h0;
         condState <= 4'h0;
      end
      else if (clkEn)
      begin
         syncA     <= rawCond;
         syncB     <= syncA;
         syncC     <= syncB;
         condState <= next_condState;
      end
   end

   // status follows the conditions; masks never touch it
   assign linear_reg_status = condState;   // see R7

   // ==========================================================================
   // registers
   logic [7:0] ldoEventMask;
   logic [7:0] next_ldoEventMask;
   logic       buckSel;
   logic       next_buckSel;
   logic       startPend;
   logic       next_startPend;
   logic [8:0] loadCurrent;
   logic [8:0] next_loadCurrent;
   logic       measBusy;
   logic       next_measBusy;

   function automatic logic hit(input lmm_pkg::lmm_regreq_t r, input logic [7:0] ofs);
      hit = (r.addr == ofs);
   endfunction

   // write decode and measurement bookkeeping
   always_comb
   begin
      next_ldoEventMask = ldoEventMask;
      next_buckSel      = buckSel;
      next_startPend    = 1'b0;
      next_loadCurrent  = loadCurrent;
      next_measBusy     = measBusy;
      if (regReq.wrEn && hit(regReq, lmm_pkg::OFS_LDO_EVENT_MASK))
         next_ldoEventMask = regReq.wdata & lmm_pkg::MASK_WRITABLE;
      if (regReq.wrEn && hit(regReq, lmm_pkg::OFS_LOAD_MEAS_SELECT))
      begin
         next_buckSel   = regReq.wdata[lmm_pkg::BIT_BUCK_SELECT];   // see R8
         next_startPend = 1'b1;                                     // see R9
      end
      // result only replaced on completion, so both bytes stay coherent
      if (measDone && measBusy)
      begin
         next_measBusy = 1'b0;
         if (buckSel == 1'b0 && dualPhase)
            next_loadCurrent = 9'(phase0Current + phase1Current);   // see R10
         else if (buckSel == 1'b0)
            next_loadCurrent = phase0Current;                       // see R11
         else
            next_loadCurrent = phase1Current;                       // see R11
      end                                                           // see R15
      if (next_startPend)
         next_measBusy = 1'b1;   // a restart wins over a completion
   end

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         ldoEventMask <= lmm_pkg::RST_LDO_EVENT_MASK;
         buckSel      <= lmm_pkg::RST_BUCK_SELECT;
         startPend    <= 1'b0;
         loadCurrent  <= lmm_pkg::RST_LOAD_CURRENT;
         measBusy     <= 1'b0;
      end
      else if (clkEn)
      begin
         ldoEventMask <= next_ldoEventMask;
         buckSel      <= next_buckSel;
         startPend    <= next_startPend;
         loadCurrent  <= next_loadCurrent;
         measBusy     <= next_measBusy;
      end
   end

   assign measStart = startPend & clkEn;
   assign measBuck  = buckSel;

   // ==========================================================================
   // read mux, combinational; unmapped offsets read zero
   always_comb
   begin
      case (regReq.addr)
         lmm_pkg::OFS_LDO_EVENT_MASK:    regRdata = ldoEventMask;
         lmm_pkg::OFS_LOAD_MEAS_SELECT:  regRdata = {7'h00, buckSel};
         lmm_pkg::OFS_LOAD_CURRENT_HIGH: regRdata = {7'h00, loadCurrent[8]};   // see R12
         lmm_pkg::OFS_LOAD_CURRENT_LOW:  regRdata = loadCurrent[7:0];          // see R13
         default:                        regRdata = 8'h00;
      endcase
   end

   // ==========================================================================
   // interrupt event generation from edges of the filtered conditions and from measurement completion
   logic [3:0] prevCond;
   logic [4:0] evt;
   logic [4:0] next_evt;
   logic       primed;

   always_comb
   begin
      next_evt    = 5'h00;
      next_evt[0] = primed && ((condState[0] && !prevCond[0]
                    && !ldoEventMask[lmm_pkg::BIT_REG0_PG_RISE])        // see R5
                    || (!condState[0] && prevCond[0]
                    && !ldoEventMask[lmm_pkg::BIT_REG0_PG_FALL]));      // see R4
      next_evt[1] = primed && condState[1] && !prevCond[1]
                    && !ldoEventMask[lmm_pkg::BIT_REG0_OC];             // see R6
      next_evt[2] = primed && ((condState[2] && !prevCond[2]
                    && !ldoEventMask[lmm_pkg::BIT_REG1_PG_RISE])        // see R2
                    || (!condState[2] && prevCond[2]
                    && !ldoEventMask[lmm_pkg::BIT_REG1_PG_FALL]));      // see R1
      next_evt[3] = primed && condState[3] && !prevCond[3]
                    && !ldoEventMask[lmm_pkg::BIT_REG1_OC];             // see R3
      next_evt[4] = measDone && measBusy && !next_startPend
                    && !meas_ready_irq_block;                           // see R14
   end

   // primed gates only the first enabled cycle after reset, while condState and prevCond both still hold zero
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         prevCond <= 4'h0;
         evt      <= 5'h00;
         primed   <= 1'b0;
      end
      else if (clkEn)
      begin
         prevCond <= condState;
         evt      <= next_evt;
         primed   <= 1'b1;
      end
   end

   assign reg0_pg_irq_flag          = evt[0];
   assign reg0_overcurrent_irq_flag = evt[1];
   assign reg1_pg_irq_flag          = evt[2];
   assign reg1_overcurrent_irq_flag = evt[3];
   assign meas_ready_irq_flag       = evt[4];

   // ==========================================================================
   // assertions
   a_reg1_fall_mask: assert property (@(posedge clk) disable iff (!resetn) // see R1
      clkEn && primed && prevCond[2] && !condState[2] && !ldoEventMask[7]
      |=> reg1_pg_irq_flag)
      else $error("regulator1 power-good fall event lost");
   a_reg1_rise_mask: assert property (@(posedge clk) disable iff (!resetn) // see R2
      clkEn && primed && !prevCond[2] && condState[2] && ldoEventMask[6]
      |=> !reg1_pg_irq_flag)
      else $error("regulator1 power-good rise not masked");
   a_reg1_oc_mask: assert property (@(posedge clk) disable iff (!resetn) // see R3
      clkEn && ldoEventMask[4] |=> !reg1_overcurrent_irq_flag)
      else $error("regulator1 overcurrent interrupt while masked");
   a_reg0_fall_mask: assert property (@(posedge clk) disable iff (!resetn) // see R4
      clkEn && primed && prevCond[0] && !condState[0] && !ldoEventMask[3]
      |=> reg0_pg_irq_flag)
      else $error("regulator0 power-good fall event lost");
   a_reg0_rise_mask: assert property (@(posedge clk) disable iff (!resetn) // see R5
      clkEn && primed && !prevCond[0] && condState[0] && ldoEventMask[2]
      |=> !reg0_pg_irq_flag)
      else $error("regulator0 power-good rise not masked");
   a_reg0_oc_mask: assert property (@(posedge clk) disable iff (!resetn) // see R6
      clkEn && ldoEventMask[0] |=> !reg0_overcurrent_irq_flag)
      else $error("regulator0 overcurrent interrupt while masked");
   a_select_start: assert property (@(posedge clk) disable iff (!resetn) // see R9
      clkEn && regReq.wrEn && regReq.addr == lmm_pkg::OFS_LOAD_MEAS_SELECT
      |=> measStart || !clkEn)
      else $error("select write did not start a measurement");
   a_result_hold: assert property (@(posedge clk) disable iff (!resetn) // see R15
      clkEn && !(measDone && measBusy) |=> $stable(loadCurrent))
      else $error("result changed without a completed measurement");
   a_high_reads: assert property (@(posedge clk) disable iff (!resetn) // see R12
      regReq.addr == lmm_pkg::OFS_LOAD_CURRENT_HIGH |-> regRdata[7:1] == 7'h00)
      else $error("upper result register reserved bits not zero");

endmodule

/* File: tb/lmm_meas_model.sv */
/* Measurement engine stand-in for the lmm_regs bench.
   Assumes one start pulse per measurement; the bench sets latency and phase loads. */
`timescale 1ns/10ps
module lmm_meas_model
(
   // clock and reset
   input  wire logic       clk,
   input  wire logic       resetn,
   // control from the slice and the bench
   input  wire logic       measStart,
   input  wire logic [3:0] latency,
   input  wire logic [8:0] load0,
   input  wire logic [8:0] load1,
   // answer to the slice
   output      logic       measDone,
   output      logic [8:0] phase0Current,
   output      logic [8:0] phase1Current
);
   // ==========================================================================
   // countdown
   logic [4:0] cnt;
   // a new start restarts the count, as a fresh select write must
   always_ff @(posedge clk or negedge resetn)
      if (!resetn)
         cnt <= 5'h00;
      else if (measStart)
         cnt <= {1'b0, latency} + 5'h01;
      else if (cnt != 5'h00)
         cnt <= cnt - 5'h01;
   // loads valid only with done; inverted otherwise so a stray sample shows up
   assign measDone      = (cnt == 5'h01);
   assign phase0Current = measDone ? load0 : ~load0;
   assign phase1Current = measDone ? load1 : ~load1;
endmodule

/* File: tb/lmm_regs_tb.sv */
/* Self-checking bench for lmm_regs: register access, event masks, measurement.
   Assumes lmm_pkg is compiled first and lmm_meas_model stands in for the engine. */
`timescale 1ns/10ps
module lmm_regs_tb;
   logic                  clk = 1'b0, resetn = 1'b0, dual = 1'b0, blk = 1'b0, clkEn = 1'b1;
   lmm_pkg::lmm_regreq_t  regReq = '0;
   lmm_pkg::lmm_regcond_t c0 = '0, c1 = '0;
   logic [7:0]            regRdata;
   logic                  measStart, measBuck, measDone, f0, f1, o0, o1, fm;
   logic [8:0]            ph0, ph1, ld0 = '0, ld1 = '0, lastRes = '0;
   logic [3:0]            lat = '0, st;
   int                    error_cnt = 0, checks = 0, n0 = 0, n1 = 0, m0 = 0, m1 = 0;

   always #12.5 clk = ~clk;

   lmm_regs u_lmm_regs (.clk(clk), .resetn(resetn), .clkEn(clkEn), .regReq(regReq),
      .regRdata(regRdata), .reg0Cond(c0), .reg1Cond(c1), .measStart(measStart),
      .measBuck(measBuck), .measDone(measDone), .phase0Current(ph0), .phase1Current(ph1),
      .dualPhase(dual), .meas_ready_irq_block(blk), .reg0_pg_irq_flag(f0),
      .reg1_pg_irq_flag(f1), .reg0_overcurrent_irq_flag(o0),
      .reg1_overcurrent_irq_flag(o1), .meas_ready_irq_flag(fm), .linear_reg_status(st));
   lmm_meas_model u_lmm_meas_model (.clk(clk), .resetn(resetn), .measStart(measStart),
      .latency(lat), .load0(ld0), .load1(ld1), .measDone(measDone),
      .phase0Current(ph0), .phase1Current(ph1));

   // ==========================================================================
   // helpers
   // tally event pulses mid-cycle, where the registered flags have settled
   always @(negedge clk)
   begin
      n0 += int'(f0);
      n1 += int'(f1);
      m0 += int'(o0);
      m1 += int'(o1);
   end
   task automatic chk(input logic [8:0] got, input logic [8:0] exp);
      checks++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("mismatch at %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      regReq = '{1'b1, 1'b0, a, d};
      @(negedge clk);
      regReq.wrEn = 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(negedge clk);
      regReq.addr = a;
      #1 chk({1'b0, regRdata}, {1'b0, e});
   endtask

   // ==========================================================================
   // scenarios
   task automatic t_access;
      rd(lmm_pkg::OFS_LDO_EVENT_MASK, 8'h00);
      rd(lmm_pkg::OFS_LOAD_MEAS_SELECT, 8'h00);
      rd(lmm_pkg::OFS_LOAD_CURRENT_HIGH, 8'h00);
      wr(lmm_pkg::OFS_LDO_EVENT_MASK, 8'hFF);
      rd(lmm_pkg::OFS_LDO_EVENT_MASK, 8'hDD);
      wr(lmm_pkg::OFS_LOAD_CURRENT_HIGH, 8'hFF);
      wr(lmm_pkg::OFS_LOAD_CURRENT_LOW, 8'hFF);
      wr(8'h27, 8'hFF);
      rd(lmm_pkg::OFS_LOAD_CURRENT_HIGH, 8'h00);
      rd(lmm_pkg::OFS_LOAD_CURRENT_LOW, 8'h00);
      rd(8'h27, 8'h00);
      $display("test access done");
   endtask
   task automatic step(input logic pg, input logic oc);
      c0 = '{pg, oc};
      c1 = '{pg, oc};
      repeat (8) @(negedge clk);
      chk({5'h00, st}, {5'h00, oc, pg, oc, pg});
   endtask
   task automatic t_mask;
      logic [7:0] tab [8] = '{8'h00, 8'hFF, 8'h80, 8'h40, 8'h10, 8'h08, 8'h04, 8'h01};
      for (int j = 0; j < 8; j++)
      begin
         wr(lmm_pkg::OFS_LDO_EVENT_MASK, tab[j]);
         n0 = 0;
         n1 = 0;
         m0 = 0;
         m1 = 0;
         step(1'b1, 1'b0);
         step(1'b0, 1'b0);
         step(1'b0, 1'b1);
         step(1'b0, 1'b0);
         chk(9'(n1), 9'(2 - tab[j][7] - tab[j][6]));
         chk(9'(m1), 9'(1 - tab[j][4]));
         chk(9'(n0), 9'(2 - tab[j][3] - tab[j][2]));
         chk(9'(m0), 9'(1 - tab[j][0]));
      end
      $display("test mask done");
   endtask
   // a low enable freezes all state, so a write in that window must be lost
   task automatic t_freeze;
      @(negedge clk);
      clkEn = 1'b0;
      wr(lmm_pkg::OFS_LDO_EVENT_MASK, 8'h11);
      rd(lmm_pkg::OFS_LDO_EVENT_MASK, 8'h01);
      clkEn = 1'b1;
      wr(lmm_pkg::OFS_LDO_EVENT_MASK, 8'h11);
      rd(lmm_pkg::OFS_LDO_EVENT_MASK, 8'h11);
      $display("test freeze done");
   endtask
   task automatic t_meas(input logic [7:0] s, input logic d, input logic k,
                         input logic [3:0] l, input logic [8:0] a0, input logic [8:0] a1,
                         input logic [8:0] e);
      int i;
      dual = d;
      blk = k;
      lat = l;
      ld0 = a0;
      ld1 = a1;
      wr(lmm_pkg::OFS_LOAD_MEAS_SELECT, s);
      regReq.addr = lmm_pkg::OFS_LOAD_CURRENT_LOW;
      // old result must stand while the engine is busy
      for (i = 0; i < 40 && measDone !== 1'b1; i++)
      begin
         @(negedge clk);
         #1 chk({1'b0, regRdata}, {1'b0, lastRes[7:0]});
      end
      chk({8'h00, measDone}, 9'h001);
      chk({8'h00, measBuck}, {8'h00, s[0]});
      @(negedge clk);
      #1 chk({8'h00, fm}, {8'h00, !k});
      chk({1'b0, regRdata}, {1'b0, e[7:0]});
      regReq.addr = lmm_pkg::OFS_LOAD_CURRENT_HIGH;
      #1 chk({1'b0, regRdata}, {8'h00, e[8]});
      lastRes = e;
      rd(lmm_pkg::OFS_LOAD_MEAS_SELECT, {7'h00, s[0]});
      $display("test meas done");
   endtask

   // ==========================================================================
   // sequence and verdict
   task automatic conclude;
      $display("checks %0d mismatches %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   initial
   begin
      repeat (16) @(posedge clk);
      @(negedge clk);
      resetn = 1'b1;
      t_access;
      t_mask;
      t_freeze;
      t_meas(8'hFE, 1'b1, 1'b0, 4'h0, 9'h100, 9'h0FF, 9'h1FF);
      t_meas(8'hFF, 1'b1, 1'b0, 4'h9, 9'h0AA, 9'h155, 9'h155);
      t_meas(8'h00, 1'b0, 1'b1, 4'h3, 9'h0F3, 9'h011, 9'h0F3);
      t_meas(8'h01, 1'b0, 1'b0, 4'hF, 9'h02C, 9'h1E0, 9'h1E0);
      conclude;
   end
   // the run needs about 360 cycles; this limit only trips on a hang
   initial
   begin
      #(25 * 20000);
      error_cnt++;
      conclude;
   end
endmodule
